/* hdl/slpcg_top.sv */
/*
  sleep mode and clock gating controller with AXI4-Lite registers.
  assumes MCLK comes from an always-on source, the core pulses
  SLEEP_INSTR once per sleep instruction, and interrupt inputs are
  already qualified by their enables, except the async EXT_IRQ pins.
*/
// Register access over AXI4-Lite and the address map were decided locally.
//
// Contract
// - sleep only if arm bit set; select picks mode
// - select 000 gives idle: core, flash stopped
// - any enabled interrupt wakes from idle
// - enabled converter starts conversion entering idle/noise
// - select 001: io, core, flash stopped
// - noise mode: timers only on external clocks
// - noise mode wakes on listed sources only
// - select 010 gives power-down: everything stopped
// - power-down wakes on listed sources only
// - power-down wake waits fuse-chosen start-up time
// - select 110 with crystal: standby, oscillator on
// - standby resumes within six cycles
// - interrupt wake holds core four extra cycles
// - register file and memory kept across sleep
// - reset during sleep restarts at reset vector
// - stop bit gates clock and blocks access
// - clearing stop bit resumes peripheral unchanged
// - peripheral stop acts in active and idle
// - comparator off removes comparator wake in idle
`timescale 1ns/1ns
module slpcg_top (
	input  wire logic                         MCLK,
	input  wire logic                         RST,
	input  wire logic [slpcg_pkg::ADDR_W-1:0] AWADDR,
	input  wire logic                         AWVALID,
	output logic                              AWREADY,
	input  wire logic [31:0]                  WDATA,
	input  wire logic [3:0]                   WSTRB,
	input  wire logic                         WVALID,
	output logic                              WREADY,
	output logic [1:0]                        BRESP,
	output logic                              BVALID,
	input  wire logic                         BREADY,
	input  wire logic [slpcg_pkg::ADDR_W-1:0] ARADDR,
	input  wire logic                         ARVALID,
	output logic                              ARREADY,
	output logic [31:0]                       RDATA,
	output logic [1:0]                        RRESP,
	output logic                              RVALID,
	input  wire logic                         RREADY,
	input  wire logic                         SLEEP_INSTR,
	input  wire logic                         IRQ_OTHER,
	input  wire logic                         COMP_IRQ,
	input  wire logic                         ADC_DONE_IRQ,
	input  wire logic                         TIMER_IRQ,
	input  wire logic                         SPM_READY_IRQ,
	input  wire logic                         PSC_IRQ,
	input  wire logic [slpcg_pkg::NEXT-1:0]   EXT_IRQ,
	input  wire logic [slpcg_pkg::NEXT-1:0]   EXT_LEVEL_EN,
	input  wire logic [slpcg_pkg::NRST-1:0]   RESET_SRC,
	input  wire logic                         ADC_ENABLED,
	input  wire logic [3:0]                   CLK_SRC_FUSES,
	output logic                              CORE_CLK_EN,
	output logic                              FLASH_CLK_EN,
	output logic                              IO_CLK_EN,
	output logic                              ADC_CLK_EN,
	output logic                              PLL_CLK_EN,
	output logic                              MAIN_OSC_EN,
	output logic [slpcg_pkg::NPERIPH-1:0]     PERIPH_CLK_EN,
	output logic [slpcg_pkg::NPERIPH-1:0]     PERIPH_IO_BLOCK,
	output logic                              TIMER_EXTCLK_ONLY,
	output logic                              ADC_AUTO_START,
	output logic                              COMP_POWER_OFF,
	output logic                              RESUME_IRQ,
	output logic                              RESUME_RESET,
	output logic                              ASLEEP
);
	import slpcg_pkg::*;

	typedef struct packed {
		slpcg_state_type    state;
		logic [2:0]         mode;
		logic               wake_rst;
		logic               arm;
		logic [2:0]         sel;
		logic [NPERIPH-1:0] stop;
		logic               comp_off;
		logic [NDOM-1:0]    dom;
		logic [NPERIPH-1:0] pclk;
		logic               adc_start;
		logic               go_irq;
		logic               go_rst;
		logic               aw_got;
		logic [ADDR_W-1:0]  aw_addr;
		logic               w_got;
		logic [7:0]         w_data;
		logic               w_en;
		logic               bvalid;
		logic [1:0]         bresp;
		logic               rvalid;
		logic [31:0]        rdata;
		logic [1:0]         rresp;
	} slpcg_regs_type;

	localparam slpcg_regs_type R_INIT = '{state: ST_ACTIVE, dom: DOM_ALL, pclk: '1, default: '0};

	slpcg_regs_type    r;
	slpcg_regs_type    next_r;
	logic [NEXT-1:0]   ext_q;
	logic              tmr_load;
	logic [CNT_W-1:0]  tmr_val;
	logic              tmr_done;
	logic              reset_any;
	logic              ext_lvl;
	logic              wake;

	// ==========================================
	// helpers
	slpcg_sync3 u_sync (
		.mclk (MCLK),
		.rst  (RST),
		.d    (EXT_IRQ),
		.q    (ext_q)
	);

	slpcg_timer u_tmr (
		.mclk (MCLK),
		.rst  (RST),
		.load (tmr_load),
		.val  (tmr_val),
		.done (tmr_done)
	);

	// ==========================================
	// wake sources per mode
	assign reset_any = |RESET_SRC;
	assign ext_lvl = |(ext_q & EXT_LEVEL_EN);

	always_comb begin
		wake = reset_any;
		unique case (r.mode)
			SEL_IDLE: begin
				wake = reset_any || IRQ_OTHER || ADC_DONE_IRQ || TIMER_IRQ
					|| SPM_READY_IRQ || PSC_IRQ || ext_lvl
					|| (COMP_IRQ && !r.comp_off);
			end
			SEL_ADCNR: begin
				wake = reset_any || ADC_DONE_IRQ || TIMER_IRQ
					|| SPM_READY_IRQ || ext_lvl;
			end
			default: begin
				wake = reset_any || PSC_IRQ || ext_lvl;
			end
		endcase
	end

	// ==========================================
	// next state
	always_comb begin
		logic [ADDR_W-1:0] wa;
		logic [ADDR_W-1:0] ra;
		next_r = r;
		wa = {r.aw_addr[ADDR_W-1:2], 2'b00};
		ra = {ARADDR[ADDR_W-1:2], 2'b00};
		tmr_load = 1'b0;
		tmr_val = '0;
		next_r.adc_start = 1'b0;
		next_r.go_irq = 1'b0;
		next_r.go_rst = 1'b0;

		// write channel
		if (AWVALID && AWREADY) begin
			next_r.aw_got = 1'b1;
			next_r.aw_addr = AWADDR;
		end
		if (WVALID && WREADY) begin
			next_r.w_got = 1'b1;
			next_r.w_data = WDATA[7:0];
			next_r.w_en = WSTRB[0];
		end
		if (r.aw_got && r.w_got) begin
			next_r.aw_got = 1'b0;
			next_r.w_got = 1'b0;
			next_r.bvalid = 1'b1;
			next_r.bresp = RESP_OKAY;
			case (wa)
				OFF_SLEEP: begin
					if (r.w_en) begin
						next_r.arm = r.w_data[ARM_BIT];
						next_r.sel = r.w_data[SEL_MSB:SEL_LSB];
					end
				end
				OFF_STOP: begin
					if (r.w_en) begin
						next_r.stop = r.w_data[NPERIPH-1:0];
					end
				end
				OFF_COMP: begin
					if (r.w_en) begin
						next_r.comp_off = r.w_data[COMP_BIT];
					end
				end
				OFF_STATUS: begin
					next_r.bresp = RESP_OKAY;
				end
				default: begin
					next_r.bresp = RESP_SLVERR;
				end
			endcase
		end
		if (r.bvalid && BREADY) begin
			next_r.bvalid = 1'b0;
		end

		// read channel
		if (ARVALID && ARREADY) begin
			next_r.rvalid = 1'b1;
			next_r.rresp = RESP_OKAY;
			case (ra)
				OFF_SLEEP: next_r.rdata = 32'({r.sel, r.arm});
				OFF_STOP: next_r.rdata = 32'(r.stop);
				OFF_COMP: next_r.rdata = 32'(r.comp_off);
				OFF_STATUS: next_r.rdata = 32'({r.state, r.mode});
				default: begin
					next_r.rdata = 32'h0000_0000;
					next_r.rresp = RESP_SLVERR;
				end
			endcase
		end
		if (r.rvalid && RREADY) begin
			next_r.rvalid = 1'b0;
		end

		// sleep sequence
		unique case (r.state)
			ST_ACTIVE: begin
				if (SLEEP_INSTR && r.arm) begin
					next_r.state = ST_SLEEP;
					next_r.mode = r.sel;
					case (r.sel)
						SEL_IDLE, SEL_ADCNR: begin
							next_r.adc_start = ADC_ENABLED;
						end
						SEL_PDOWN: begin
							next_r.mode = SEL_PDOWN;
						end
						SEL_STBY: begin
							if (!CLK_SRC_FUSES[XTAL_BIT]) begin
								next_r.mode = SEL_PDOWN;
							end
						end
						default: begin
							next_r.state = ST_ACTIVE;
							next_r.mode = r.mode;
						end
					endcase
				end
			end
			ST_SLEEP: begin
				if (wake) begin
					next_r.wake_rst = reset_any;
					tmr_load = 1'b1;
					if (r.mode == SEL_IDLE || r.mode == SEL_ADCNR) begin
						next_r.state = ST_HOLD;
						tmr_val = CNT_W'(HOLD_CYC - 1);
					end else if (r.mode == SEL_STBY) begin
						next_r.state = ST_STARTUP;
						tmr_val = CNT_W'(STBY_START_CYC - 1);
					end else begin
						next_r.state = ST_STARTUP;
						tmr_val = PD_START[CLK_SRC_FUSES[1:0]] - 16'h0001;
					end
				end
			end
			ST_STARTUP: begin
				next_r.wake_rst = r.wake_rst || reset_any;
				if (tmr_done) begin
					next_r.state = ST_HOLD;
					tmr_load = 1'b1;
					tmr_val = CNT_W'(HOLD_CYC - 1);
				end
			end
			ST_HOLD: begin
				next_r.wake_rst = r.wake_rst || reset_any;
				if (tmr_done) begin
					next_r.state = ST_ACTIVE;
					next_r.go_irq = !next_r.wake_rst;
					next_r.go_rst = next_r.wake_rst;
				end
			end
		endcase

		// clock domains follow the next state
		unique case (next_r.state)
			ST_ACTIVE: next_r.dom = DOM_ALL;
			ST_HOLD: next_r.dom = DOM_HOLD;
			ST_STARTUP: next_r.dom = DOM_START;
			ST_SLEEP: begin
				case (next_r.mode)
					SEL_IDLE: next_r.dom = DOM_IDLE;
					SEL_ADCNR: next_r.dom = DOM_ADCNR;
					SEL_STBY: next_r.dom = DOM_STBY;
					default: next_r.dom = DOM_PDOWN;
				endcase
			end
		endcase
		next_r.pclk = {NPERIPH{next_r.dom[DOM_IO]}} & ~next_r.stop;
	end

	always_ff @(posedge MCLK) begin
		if (RST) begin
			r <= R_INIT;
		end else begin
			r <= next_r;
		end
	end

	// ==========================================
	// outputs
	assign AWREADY = !r.aw_got && !r.bvalid;
	assign WREADY = !r.w_got && !r.bvalid;
	assign BVALID = r.bvalid;
	assign BRESP = r.bresp;
	assign ARREADY = !r.rvalid;
	assign RVALID = r.rvalid;
	assign RDATA = r.rdata;
	assign RRESP = r.rresp;
	assign CORE_CLK_EN = r.dom[DOM_CORE];
	assign FLASH_CLK_EN = r.dom[DOM_FLASH];
	assign IO_CLK_EN = r.dom[DOM_IO];
	assign ADC_CLK_EN = r.dom[DOM_ADC];
	assign PLL_CLK_EN = r.dom[DOM_PLL];
	assign MAIN_OSC_EN = r.dom[DOM_OSC];
	assign PERIPH_CLK_EN = r.pclk;
	assign PERIPH_IO_BLOCK = r.stop;
	assign TIMER_EXTCLK_ONLY = !r.dom[DOM_IO] && r.dom[DOM_ADC];
	assign ADC_AUTO_START = r.adc_start;
	assign COMP_POWER_OFF = r.comp_off;
	assign RESUME_IRQ = r.go_irq;
	assign RESUME_RESET = r.go_rst;
	assign ASLEEP = (r.state != ST_ACTIVE);

	// ==========================================
	// checks
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (RST);

	sequence s_hold4;
		(r.state == ST_HOLD)[*4] ##1 (r.state == ST_ACTIVE);
	endsequence

	a_arm_gate: assert property (
		r.state == ST_ACTIVE && SLEEP_INSTR && !r.arm |=> !ASLEEP && CORE_CLK_EN)
		else $error("sleep taken with arm bit clear");

	a_sleep_entry: assert property (
		r.state == ST_ACTIVE && SLEEP_INSTR && r.arm && r.sel == SEL_PDOWN
		|=> ASLEEP && r.mode == SEL_PDOWN)
		else $error("armed sleep did not enter selected mode");

	a_idle_domains: assert property (
		r.state == ST_SLEEP && r.mode == SEL_IDLE
		|-> !CORE_CLK_EN && !FLASH_CLK_EN && IO_CLK_EN && ADC_CLK_EN && PLL_CLK_EN && MAIN_OSC_EN)
		else $error("idle clock domains wrong");

	a_adcnr_domains: assert property (
		r.state == ST_SLEEP && r.mode == SEL_ADCNR
		|-> !IO_CLK_EN && !CORE_CLK_EN && ADC_CLK_EN && PLL_CLK_EN && TIMER_EXTCLK_ONLY)
		else $error("noise mode clock domains wrong");

	a_pdown_domains: assert property (
		r.state == ST_SLEEP && r.mode == SEL_PDOWN |-> r.dom == DOM_PDOWN)
		else $error("power-down left a clock running");

	a_stby_osc: assert property (
		r.state == ST_SLEEP && r.mode == SEL_STBY |-> MAIN_OSC_EN && !IO_CLK_EN)
		else $error("standby oscillator wrong");

	a_stby_resume: assert property (
		r.state == ST_SLEEP && r.mode == SEL_STBY && wake
		|-> ##6 !CORE_CLK_EN ##1 CORE_CLK_EN)
		else $error("standby resume not at six cycles");

	a_hold_four: assert property (
		r.state == ST_STARTUP && tmr_done |=> s_hold4)
		else $error("core hold not four cycles");

	a_adc_autostart: assert property (
		r.state == ST_ACTIVE && SLEEP_INSTR && r.arm && ADC_ENABLED
		&& (r.sel == SEL_IDLE || r.sel == SEL_ADCNR) |=> ADC_AUTO_START)
		else $error("conversion not started on sleep entry");

	a_periph_stop: assert property (
		(PERIPH_CLK_EN & PERIPH_IO_BLOCK) == '0
		&& PERIPH_CLK_EN == ({NPERIPH{IO_CLK_EN}} & ~PERIPH_IO_BLOCK))
		else $error("stopped peripheral still clocked");

	a_reset_vector: assert property (
		r.state == ST_SLEEP && r.mode == SEL_IDLE && reset_any
		|-> ##5 RESUME_RESET && !RESUME_IRQ)
		else $error("reset wake did not restart at vector");

	a_pdown_wake: assert property (
		r.state == ST_SLEEP && r.mode == SEL_PDOWN && !reset_any && !PSC_IRQ && !ext_lvl
		|=> r.state == ST_SLEEP)
		else $error("power-down woke on a foreign source");
endmodule

/* hdl/slpcg_pkg.sv */
/*
  constants and types of the sleep mode and clock gating controller.
  assumes a 32-bit AXI4-Lite register bus with 8-bit byte addresses.
*/
package slpcg_pkg;
	// ==========================================
	// register map
	localparam int         ADDR_W      = 8;
	localparam logic [7:0] OFF_SLEEP   = 8'h00;
	localparam logic [7:0] OFF_STOP    = 8'h04;
	localparam logic [7:0] OFF_COMP    = 8'h08;
	localparam logic [7:0] OFF_STATUS  = 8'h0C;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int         ARM_BIT     = 0;
	localparam int         SEL_LSB     = 1;
	localparam int         SEL_MSB     = 3;
	localparam int         COMP_BIT    = 0;
	localparam int         NPERIPH     = 7;
	localparam int         NEXT        = 4;
	localparam int         NRST        = 3;
	localparam int         XTAL_BIT    = 3;
	// ==========================================
	// sleep select codes
	localparam logic [2:0] SEL_IDLE    = 3'h0;
	localparam logic [2:0] SEL_ADCNR   = 3'h1;
	localparam logic [2:0] SEL_PDOWN   = 3'h2;
	localparam logic [2:0] SEL_STBY    = 3'h6;
	// ==========================================
	// clock domain enables: core, flash, io, adc, pll, osc
	localparam int         NDOM        = 6;
	localparam int         DOM_CORE    = 0;
	localparam int         DOM_FLASH   = 1;
	localparam int         DOM_IO      = 2;
	localparam int         DOM_ADC     = 3;
	localparam int         DOM_PLL     = 4;
	localparam int         DOM_OSC     = 5;
	localparam logic [5:0] DOM_ALL     = 6'h3F;
	localparam logic [5:0] DOM_HOLD    = 6'h3C;
	localparam logic [5:0] DOM_IDLE    = 6'h3C;
	localparam logic [5:0] DOM_ADCNR   = 6'h38;
	localparam logic [5:0] DOM_PDOWN   = 6'h00;
	localparam logic [5:0] DOM_STBY    = 6'h20;
	localparam logic [5:0] DOM_START   = 6'h20;
	// ==========================================
	// wake-up timing in cycles
	localparam int          CNT_W      = 16;
	localparam int          HOLD_CYC   = 4;
	localparam int          STBY_RESUME_CYC = 6;
	localparam int          STBY_START_CYC  = STBY_RESUME_CYC - HOLD_CYC;
	localparam logic [15:0] PD_START [4] = '{16'h0010, 16'h0040, 16'h0100, 16'h0400};

	typedef enum logic [1:0] {ST_ACTIVE, ST_SLEEP, ST_STARTUP, ST_HOLD} slpcg_state_type;
endpackage

/* hdl/slpcg_sync3.sv */
/*
  three-stage synchroniser for the external interrupt lines.
  assumes asynchronous inputs; output changes once stages two and three agree.
*/
`timescale 1ns/1ns
module slpcg_sync3 (
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic [3:0] d,
	output logic      [3:0] q
);
	typedef struct packed {
		logic [3:0] s1;
		logic [3:0] s2;
		logic [3:0] s3;
		logic [3:0] q;
	} slpcg_sync_type;

	slpcg_sync_type r;
	slpcg_sync_type next_r;

	// ==========================================
	// stages
	always_comb begin
		next_r = r;
		next_r.s1 = d;
		next_r.s2 = r.s1;
		next_r.s3 = r.s2;
		next_r.q = ((r.s2 ^ r.s3) & r.q) | (~(r.s2 ^ r.s3) & r.s2);
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign q = r.q;
endmodule

/* hdl/slpcg_timer.sv */
/*
  down counter that times the clock start-up and the core hold.
  assumes load pulses come from the controller on the same clock.
*/
`timescale 1ns/1ns
module slpcg_timer (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        load,
	input  wire logic [15:0] val,
	output logic             done
);
	typedef struct packed {
		logic [15:0] cnt;
	} slpcg_tmr_type;

	slpcg_tmr_type r;
	slpcg_tmr_type next_r;

	// ==========================================
	// count
	always_comb begin
		next_r = r;
		if (load) begin
			next_r.cnt = val;
		end else if (r.cnt != 16'h0000) begin
			next_r.cnt = r.cnt - 16'h0001;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign done = (r.cnt == 16'h0000);
endmodule

/* dv/slpcg_core_model.sv */
/*
  core and interrupt-source model facing the sleep controller.
  assumes the bench asks for sleeps and external levels on MCLK.
*/
`timescale 1ns/1ns
module slpcg_core_model (
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic       go,
	input  wire logic [3:0] ext_req,
	input  wire logic       asleep,
	output logic            sleep_instr,
	output logic      [3:0] ext_irq
);
	// ==========================================
	// sleep pulse and held wake level
	always_ff @(posedge mclk) begin
		if (rst) begin
			sleep_instr <= 1'b0;
			ext_irq     <= 4'h0;
		end else begin
			sleep_instr <= go;
			ext_irq     <= ext_req | (ext_irq & {4{asleep}});
		end
	end
endmodule

/* dv/slpcg_top_tb.sv */
/*
  self-checking bench for the sleep mode and clock gating controller.
  assumes slpcg_pkg, slpcg_top and slpcg_core_model are compiled first.
*/
`timescale 1ns/1ns
module slpcg_top_tb;
	import slpcg_pkg::*;
	// ==========================================
	// signals
	logic        MCLK, RST, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY, go;
	logic        ARVALID, ARREADY, RVALID, RREADY, SLEEP_INSTR, ADC_ENABLED, ASLEEP;
	logic        CORE_CLK_EN, FLASH_CLK_EN, IO_CLK_EN, ADC_CLK_EN, PLL_CLK_EN;
	logic        MAIN_OSC_EN, TIMER_EXTCLK_ONLY, ADC_AUTO_START, COMP_POWER_OFF;
	logic        RESUME_IRQ, RESUME_RESET;
	logic [7:0]  AWADDR, ARADDR;
	logic [31:0] WDATA, RDATA;
	logic [3:0]  WSTRB, EXT_IRQ, EXT_LEVEL_EN, CLK_SRC_FUSES, ext_req;
	logic [1:0]  BRESP, RRESP;
	logic [2:0]  RESET_SRC;
	logic [5:0]  irq_v, dom;
	logic [6:0]  PERIPH_CLK_EN, PERIPH_IO_BLOCK;
	int          miscompares, checked;
	assign dom = {MAIN_OSC_EN, PLL_CLK_EN, ADC_CLK_EN, IO_CLK_EN, FLASH_CLK_EN, CORE_CLK_EN};
	slpcg_top uut (
		.MCLK(MCLK), .RST(RST), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
		.WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
		.BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
		.ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
		.SLEEP_INSTR(SLEEP_INSTR), .IRQ_OTHER(irq_v[0]), .COMP_IRQ(irq_v[1]),
		.ADC_DONE_IRQ(irq_v[2]), .TIMER_IRQ(irq_v[3]), .SPM_READY_IRQ(irq_v[4]),
		.PSC_IRQ(irq_v[5]), .EXT_IRQ(EXT_IRQ), .EXT_LEVEL_EN(EXT_LEVEL_EN),
		.RESET_SRC(RESET_SRC), .ADC_ENABLED(ADC_ENABLED), .CLK_SRC_FUSES(CLK_SRC_FUSES),
		.CORE_CLK_EN(CORE_CLK_EN), .FLASH_CLK_EN(FLASH_CLK_EN), .IO_CLK_EN(IO_CLK_EN),
		.ADC_CLK_EN(ADC_CLK_EN), .PLL_CLK_EN(PLL_CLK_EN), .MAIN_OSC_EN(MAIN_OSC_EN),
		.PERIPH_CLK_EN(PERIPH_CLK_EN), .PERIPH_IO_BLOCK(PERIPH_IO_BLOCK),
		.TIMER_EXTCLK_ONLY(TIMER_EXTCLK_ONLY), .ADC_AUTO_START(ADC_AUTO_START),
		.COMP_POWER_OFF(COMP_POWER_OFF), .RESUME_IRQ(RESUME_IRQ),
		.RESUME_RESET(RESUME_RESET), .ASLEEP(ASLEEP)
	);
	slpcg_core_model core (
		.mclk(MCLK), .rst(RST), .go(go), .ext_req(ext_req), .asleep(ASLEEP),
		.sleep_instr(SLEEP_INSTR), .ext_irq(EXT_IRQ)
	);
	initial begin
		MCLK = 1'b0;
		forever #5 MCLK = ~MCLK;
	end
	initial begin
		repeat (20000) @(posedge MCLK);
		miscompares++;
		report_and_stop();
	end
	// ==========================================
	// shared tasks
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge MCLK);
		AWADDR <= a;
		WDATA <= d;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		BREADY <= 1'b1;
		do begin
			@(posedge MCLK);
			if (AWREADY === 1'b1) AWVALID <= 1'b0;
			if (WREADY === 1'b1) WVALID <= 1'b0;
		end while (BVALID !== 1'b1);
		BREADY <= 1'b0;
		cmp(BRESP, er);
	endtask
	task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge MCLK);
		ARADDR <= a;
		ARVALID <= 1'b1;
		RREADY <= 1'b1;
		do begin
			@(posedge MCLK);
			if (ARREADY === 1'b1) ARVALID <= 1'b0;
		end while (RVALID !== 1'b1);
		RREADY <= 1'b0;
		cmp(RDATA, ed);
		cmp(RRESP, er);
	endtask
	task automatic enter(input logic [2:0] sel, input logic arm, input logic [5:0] de,
		input logic es, input logic ea);
		axi_wr(OFF_SLEEP, {28'h000_0000, sel, arm}, RESP_OKAY);
		@(posedge MCLK);
		go <= 1'b1;
		@(posedge MCLK);
		go <= 1'b0;
		@(posedge MCLK);
		#1;
		cmp(ASLEEP, es);
		cmp(ADC_AUTO_START, ea);
		cmp(dom, de);
	endtask
	task automatic wake(input logic [5:0] v, input logic [2:0] rs, input logic [3:0] e,
		input int lo, input int hi, input logic er);
		int n;
		@(posedge MCLK);
		irq_v <= v;
		RESET_SRC <= rs;
		ext_req <= e;
		for (n = 1; n < 3000; n++) begin
			@(posedge MCLK);
			ext_req <= 4'h0;
			#1;
			if ((RESUME_IRQ | RESUME_RESET) === 1'b1) break;
		end
		cmp(n >= lo && n <= hi, 1'b1);
		cmp(RESUME_RESET, er);
		cmp(RESUME_IRQ, !er);
		cmp(ASLEEP, 1'b0);
		@(posedge MCLK);
		irq_v <= 6'h00;
		RESET_SRC <= 3'h0;
	endtask
	task automatic ignore(input logic [5:0] v);
		@(posedge MCLK);
		irq_v <= v;
		repeat (30) @(posedge MCLK);
		#1;
		cmp(ASLEEP, 1'b1);
		@(posedge MCLK);
		irq_v <= 6'h00;
	endtask
	// ==========================================
	// scenarios
	task automatic t_noop();
		enter(SEL_IDLE, 1'b0, DOM_ALL, 1'b0, 1'b0);
		enter(3'h3, 1'b1, DOM_ALL, 1'b0, 1'b0);
		axi_rd(OFF_SLEEP, 32'h0000_0007, RESP_OKAY);
	endtask
	task automatic t_stop();
		axi_wr(OFF_STOP, 32'h0000_0055, RESP_OKAY);
		@(posedge MCLK);
		#1;
		cmp(PERIPH_CLK_EN, 7'h2A);
		cmp(PERIPH_IO_BLOCK, 7'h55);
		axi_rd(OFF_STOP, 32'h0000_0055, RESP_OKAY);
		enter(SEL_IDLE, 1'b1, DOM_IDLE, 1'b1, 1'b1);
		cmp(PERIPH_CLK_EN, 7'h2A);
		wake(6'h01, 3'h0, 4'h0, 5, 5, 1'b0);
		enter(SEL_ADCNR, 1'b1, DOM_ADCNR, 1'b1, 1'b1);
		@(posedge MCLK);
		#1;
		cmp(PERIPH_CLK_EN, 7'h00);
		wake(6'h04, 3'h0, 4'h0, 5, 5, 1'b0);
		axi_wr(OFF_STOP, 32'h0000_0000, RESP_OKAY);
		@(posedge MCLK);
		#1;
		cmp(PERIPH_CLK_EN, 7'h7F);
		axi_rd(8'h10, 32'h0000_0000, RESP_SLVERR);
		axi_wr(8'h10, 32'h0000_0001, RESP_SLVERR);
	endtask
	task automatic t_idle();
		axi_wr(OFF_COMP, 32'h0000_0001, RESP_OKAY);
		enter(SEL_IDLE, 1'b1, DOM_IDLE, 1'b1, 1'b1);
		cmp(COMP_POWER_OFF, 1'b1);
		ignore(6'h02);
		wake(6'h01, 3'h0, 4'h0, 5, 5, 1'b0);
		axi_wr(OFF_COMP, 32'h0000_0000, RESP_OKAY);
		enter(SEL_IDLE, 1'b1, DOM_IDLE, 1'b1, 1'b1);
		wake(6'h02, 3'h0, 4'h0, 5, 5, 1'b0);
		enter(SEL_IDLE, 1'b1, DOM_IDLE, 1'b1, 1'b1);
		wake(6'h00, 3'h1, 4'h0, 1, 10, 1'b1);
	endtask
	task automatic t_noise();
		logic [5:0] src [3] = '{6'h04, 6'h08, 6'h10};
		for (int i = 0; i < 3; i++) begin
			enter(SEL_ADCNR, 1'b1, DOM_ADCNR, 1'b1, 1'b1);
			cmp(TIMER_EXTCLK_ONLY, 1'b1);
			ignore(6'h03);
			wake(src[i], 3'h0, 4'h0, 5, 5, 1'b0);
		end
	endtask
	task automatic t_pdown();
		int pd;
		pd = PD_START[1] + HOLD_CYC + 1;
		@(posedge MCLK);
		CLK_SRC_FUSES <= 4'h1;
		enter(SEL_PDOWN, 1'b1, DOM_PDOWN, 1'b1, 1'b0);
		ignore(6'h1F);
		wake(6'h20, 3'h0, 4'h0, pd, pd + 2, 1'b0);
		enter(SEL_STBY, 1'b1, DOM_PDOWN, 1'b1, 1'b0);
		wake(6'h00, 3'h0, 4'h4, pd, pd + 8, 1'b0);
		@(posedge MCLK);
		CLK_SRC_FUSES <= 4'h9;
		enter(SEL_STBY, 1'b1, DOM_STBY, 1'b1, 1'b0);
		wake(6'h20, 3'h0, 4'h0, STBY_RESUME_CYC + 1, STBY_RESUME_CYC + 1, 1'b0);
		axi_wr(OFF_STATUS, 32'h0000_001F, RESP_OKAY);
		axi_rd(OFF_STATUS, 32'h0000_0006, RESP_OKAY);
	endtask
	task automatic report_and_stop();
		if (miscompares == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// ==========================================
	// main sequence
	initial begin
		RST = 1'b1;
		{AWVALID, WVALID, BREADY, ARVALID, RREADY, go} = 6'h00;
		{AWADDR, ARADDR} = 16'h0000;
		WDATA = 32'h0000_0000;
		{WSTRB, EXT_LEVEL_EN, CLK_SRC_FUSES, ext_req} = 16'hFF00;
		{irq_v, RESET_SRC} = 9'h000;
		ADC_ENABLED = 1'b1;
		miscompares = 0;
		checked = 0;
		repeat (5) @(posedge MCLK);
		RST <= 1'b0;
		t_noop();
		t_stop();
		t_idle();
		t_noise();
		t_pdown();
		report_and_stop();
	end
endmodule
